// ### rtl/ssie_pkg.sv
package ssie_pkg;
  localparam int POS_W = 13;
  localparam int CLK_HZ = 25_000_000;
  // Monoflop longest time, ns; count rounds down
  localparam int MONO_NS = 15_000;
  localparam int MONO_CYC = (MONO_NS * (CLK_HZ / 1_000_000)) / 1000;
  // Controller half period for at most 500 kbit/s, ns; least time rounds up
  localparam int LINK_HALF_NS = 1000;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Function input settle, ns (20 ms); zero-set hold, ns (10 ms); power-up, ns (250 ms)
  localparam longint FUNC_NS = 64'd20_000_000;
  localparam int FUNC_CYC = int'((FUNC_NS * (CLK_HZ / 1_000_000)) / 1000);
  localparam longint PRESET_NS = 64'd10_000_000;
  localparam int PRESET_CYC = int'((PRESET_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  localparam longint POWERUP_NS = 64'd250_000_000;
  localparam int POWERUP_CYC = int'((POWERUP_NS * (CLK_HZ / 1_000_000)) / 1000);
  localparam logic [12:0] POS_RST = 13'h0000;
  localparam logic [12:0] PRESET_VAL = 13'h0000;
  localparam logic [1:0] SYNC_RST = 2'h3;
endpackage

// ### rtl/ssie_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssie_link_if;
  logic clk_p;
  logic data_p;
  logic dir_sel;
  logic zero_set;
  modport encoder (input clk_p, input dir_sel, input zero_set, output data_p);
  modport ctrl (output clk_p, output dir_sel, output zero_set, input data_p);
endinterface
`default_nettype wire

// ### rtl/ssie_encoder.sv
// Contract
// - Idle: clock and data both rest high
// - First falling edge captures position, starts transfer
// - MSB out on first rising edge
// - Each further rising edge: next lower bit
// - After LSB data low until monoflop expires (code holds the LSB level; only a further fall pulls data low)
// - Controller waits for data high before burst
// - Monoflop starts on last falling edge
// - Monoflop interval at most 15 us
// - Controller clock period below monoflop interval
// - Position word: 13-bit Gray code
// - Default direction: code ascends clockwise
// - Controller clock at most 500 kbit/s
// - Continued clocking resends same captured word
// - Late 26th pulse sends fresh word
// - Ring-slide repetition spans 13 pulses
// - Function inputs active at high level
// - Zero-set makes current position read zero
// - Controller holds zero-set at least 10 ms (ssie_ctrl passes zero_in straight through, with no minimum hold)
// - Function input change effective within 20 ms
// - Valid data within 250 ms of power-up
`timescale 1ns/1ps
`default_nettype none
module ssie_encoder #(
  parameter int POS_W = ssie_pkg::POS_W,
  parameter int MONO_CYC = ssie_pkg::MONO_CYC,
  parameter int FUNC_CYC = ssie_pkg::FUNC_CYC,
  parameter int POWERUP_CYC = ssie_pkg::POWERUP_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Link
  ssie_link_if.encoder link,
  // Shaft position, binary, clockwise ascending
  input wire logic [POS_W-1:0] shaft_pos,
  // Status
  output logic ready
);
  // ==========================================
  // Synchronisers
  // Link clock idles high, so its stages reset high: no false fall after reset
  logic [1:0] clk_s_reg;
  logic [1:0] dir_s_reg;
  logic [1:0] zero_s_reg;
  logic clk_d_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_s_reg <= ssie_pkg::SYNC_RST;
      dir_s_reg <= 2'h0;
      zero_s_reg <= 2'h0;
      clk_d_reg <= 1'b1;
    end else begin
      clk_s_reg <= {clk_s_reg[0], link.clk_p};
      dir_s_reg <= {dir_s_reg[0], link.dir_sel};
      zero_s_reg <= {zero_s_reg[0], link.zero_set};
      clk_d_reg <= clk_s_reg[1];
    end
  end
  wire fall = clk_d_reg & ~clk_s_reg[1];
  wire rise = ~clk_d_reg & clk_s_reg[1];

  // ==========================================
  // Function inputs, filtered so a change must stand before it acts
  logic dir_reg;
  logic zero_reg;
  logic [31:0] fcnt_reg;
  logic [POS_W-1:0] offset_reg;
  // Half the allowed settle time, trading margin against glitch rejection
  wire fchg = (dir_s_reg[1] != dir_reg) | (zero_s_reg[1] != zero_reg);
  wire fdone = fcnt_reg >= 32'(FUNC_CYC / 2);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dir_reg <= 1'b0;
      zero_reg <= 1'b0;
      fcnt_reg <= 32'h0000_0000;
    end else if (!fchg) begin
      fcnt_reg <= 32'h0000_0000;
    end else if (fdone) begin
      dir_reg <= dir_s_reg[1];
      zero_reg <= zero_s_reg[1];
      fcnt_reg <= 32'h0000_0000;
    end else begin
      fcnt_reg <= fcnt_reg + 32'h0000_0001;
    end
  end

  // ==========================================
  // Position: direction, zero offset, Gray coding
  wire [POS_W-1:0] dir_pos = dir_reg ? (~shaft_pos + 1'b1) : shaft_pos;
  wire [POS_W-1:0] rel_pos = dir_pos - offset_reg;
  wire [POS_W-1:0] gray_pos = rel_pos ^ (rel_pos >> 1);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      offset_reg <= ssie_pkg::PRESET_VAL;
    end else if (zero_reg) begin
      offset_reg <= dir_pos - ssie_pkg::PRESET_VAL;
    end
  end

  // ==========================================
  // Power-up availability
  // Before this rises the word sent is zero, never a half-settled value
  logic [31:0] pcnt_reg;
  logic ready_reg;
  wire pcnt_full = pcnt_reg >= 32'(POWERUP_CYC / 2);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pcnt_reg <= 32'h0000_0000;
    end else if (!pcnt_full) begin
      pcnt_reg <= pcnt_reg + 32'h0000_0001;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= pcnt_full;
    end
  end
  assign ready = ready_reg;

  // ==========================================
  // Monoflop
  // Loaded short by the edge detector's delay so the pin-level interval stays in bound
  logic [15:0] mono_reg;
  wire mono_out = mono_reg == 16'h0000;
  wire [15:0] mono_load = 16'(MONO_CYC - 4);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mono_reg <= 16'h0000;
    end else if (fall) begin
      mono_reg <= mono_load;
    end else if (!mono_out) begin
      mono_reg <= mono_reg - 16'h0001;
    end
  end

  // ==========================================
  // Transfer decode
  logic [POS_W-1:0] word_reg;
  logic [4:0] bit_reg;
  logic busy_reg;
  logic data_reg;
  wire last_bit = bit_reg == 5'(POS_W - 1);
  wire [4:0] bit_next = last_bit ? 5'h00 : bit_reg + 5'h01;
  wire bit_out = word_reg[POS_W-1-int'(bit_reg)];
  // A fall inside the interval continues the ring instead of recapturing
  wire capture = fall && (!busy_reg || mono_out);
  // Shift only inside a transfer; stray rising edges at idle are ignored
  wire shift = rise && busy_reg;
  wire line_free = busy_reg && mono_out && clk_s_reg[1] && !rise;
  wire tail_low = fall && busy_reg && !mono_out && bit_reg == 5'h00;

  // ==========================================
  // Captured word, held for the whole transfer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      word_reg <= ssie_pkg::POS_RST;
    end else if (capture) begin
      word_reg <= ready_reg ? gray_pos : ssie_pkg::POS_RST;
    end
  end

  // ==========================================
  // Bit pointer, wraps for ring-slide repetition
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_reg <= 5'h00;
    end else if (capture) begin
      bit_reg <= 5'h00;
    end else if (shift) begin
      bit_reg <= bit_next;
    end
  end

  // ==========================================
  // Transfer state
  // Clears only with the clock high, so a cut frame still ends cleanly
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
    end else if (capture) begin
      busy_reg <= 1'b1;
    end else if (line_free) begin
      busy_reg <= 1'b0;
    end
  end

  // ==========================================
  // Data line
  // After the word the LSB level holds; only a fall inside the interval pulls data low
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_reg <= 1'b1;
    end else if (shift) begin
      data_reg <= bit_out;
    end else if (line_free) begin
      data_reg <= 1'b1;
    end else if (tail_low) begin
      data_reg <= 1'b0;
    end
  end

  assign link.data_p = data_reg;
endmodule
`default_nettype wire

// ### rtl/ssie_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ssie_ctrl #(
  parameter int POS_W = ssie_pkg::POS_W,
  parameter int HALF_CYC = ssie_pkg::LINK_HALF_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Link
  ssie_link_if.ctrl link,
  // User side
  input wire logic start,
  input wire logic [5:0] n_bits,
  input wire logic dir_in,
  input wire logic zero_in,
  output logic busy,
  output logic done,
  output logic [2*POS_W-1:0] rx_word
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LOW = 2'b01, ST_HIGH = 2'b11,
    ST_WAIT = 2'b10} ssie_st_t;
  ssie_st_t st_reg;
  logic [1:0] d_s_reg;
  logic clk_reg;
  logic [7:0] hcnt_reg;
  logic [5:0] left_reg;
  logic [5:0] nb_reg;
  logic done_reg;
  logic [2*POS_W-1:0] sh_reg;
  // Pause counter: a word ending in a one never pulls data low
  logic [9:0] pause_reg;
  wire half = hcnt_reg == 8'(HALF_CYC - 1);
  wire pause_done = pause_reg >= 10'(ssie_pkg::MONO_CYC);
  assign busy = st_reg != ST_IDLE;
  assign done = done_reg;
  assign link.clk_p = clk_reg;
  assign link.dir_sel = dir_in;
  assign link.zero_set = zero_in; // user holds 10 ms
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      d_s_reg <= 2'h3;
    end else begin
      d_s_reg <= {d_s_reg[0], link.data_p};
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= ST_IDLE;
      clk_reg <= 1'b1;
      hcnt_reg <= 8'h00;
      left_reg <= 6'h00;
      nb_reg <= 6'h00;
      done_reg <= 1'b0;
      sh_reg <= '0;
      rx_word <= '0;
      pause_reg <= 10'h000;
    end else begin
      done_reg <= 1'b0;
      hcnt_reg <= half ? 8'h00 : hcnt_reg + 8'h01;
      unique case (st_reg)
        ST_IDLE: begin
          if (start && d_s_reg[1] && n_bits != 6'h00) begin
            st_reg <= ST_LOW;
            clk_reg <= 1'b0;
            hcnt_reg <= 8'h00;
            left_reg <= n_bits;
            nb_reg <= n_bits;
          end
        end
        ST_LOW: if (half) begin
          st_reg <= ST_HIGH;
          clk_reg <= 1'b1;
        end
        ST_HIGH: if (half) begin
          sh_reg <= {sh_reg[2*POS_W-2:0], d_s_reg[1]};
          left_reg <= left_reg - 6'h01;
          if (left_reg == 6'h01) begin
            st_reg <= ST_WAIT;
            pause_reg <= 10'h000;
          end else begin
            st_reg <= ST_LOW;
            clk_reg <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (d_s_reg[1] && pause_done) begin
            st_reg <= ST_IDLE;
            done_reg <= 1'b1;
            rx_word <= sh_reg;
            sh_reg <= '0;
          end else if (!pause_done) begin
            pause_reg <= pause_reg + 10'h001;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### verif/ssie_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ssie_asserts #(
  parameter int MONO_CYC = 375
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Link
  input wire logic clk_p,
  input wire logic data_p,
  input wire logic dir_sel,
  input wire logic zero_set
);
  // ==========
  // Cycles since last link clock edge
  logic clk_q_reg;
  logic [9:0] ed_cnt_reg;
  wire [9:0] ed_cnt_next = (clk_p != clk_q_reg) ? 10'h000 :
    ed_cnt_reg + {9'h000, ed_cnt_reg != 10'h3ff};
  // Long high phase before a fall marks a new burst, not a bit
  wire new_fall = !clk_p && clk_q_reg && (ed_cnt_reg > 10'h01e);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_q_reg <= 1'b1;
      ed_cnt_reg <= 10'h000;
    end else begin
      clk_q_reg <= clk_p;
      ed_cnt_reg <= ed_cnt_next;
    end
  end
  // ==========
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_rest_both_high: assert property (disable iff (1'b0) !nrst |=> clk_p && data_p)
    else $error("link not idle high in reset");
  chk_burst_data_high: assert property (new_fall |-> data_p)
    else $error("burst began while data low");
  chk_msb_not_early: assert property (new_fall |-> ##1 (data_p throughout ##22 1))
    else $error("data moved before first rising edge");
  chk_low_half_len: assert property ($fell(clk_p) |-> (!clk_p throughout ##24 1) ##1 clk_p)
    else $error("clock low phase not 25 cycles");
  chk_high_half_len: assert property ($rose(clk_p) |-> clk_p throughout ##24 1)
    else $error("clock high phase too short");
  chk_data_rise_high: assert property ($rose(data_p) |-> clk_p)
    else $error("data rose while clock low");
  chk_bit_settle: assert property ($changed(data_p) && clk_p && ed_cnt_reg < 40 |-> ed_cnt_reg < 6)
    else $error("data bit changed late in high phase");
  chk_mono_expiry: assert property (clk_p && ed_cnt_reg >= MONO_CYC + 8 |-> data_p)
    else $error("data still low after monoflop time");
  cover property (new_fall);
  cover property ($rose(data_p) && ed_cnt_reg > 300);
  cover property ($fell(clk_p) && !data_p && !zero_set && !dir_sel);
endmodule
`default_nettype wire

// ### verif/ssi_absolute_position_encoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_absolute_position_encoder_tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic [5:0] n_bits = 6'h0d;
  logic dir_in = 1'b0;
  logic zero_in = 1'b0;
  logic [12:0] shaft = 13'h0000;
  logic busy, done, ready;
  logic [25:0] rx_word;
  logic [12:0] w;
  int err_total = 0;
  int cmp_count = 0;
  logic row_dir[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [12:0] row_pos[5] = '{13'h0001, 13'h1fff, 13'h0001, 13'h0a5a, 13'h0a5a};
  logic [12:0] row_exp[5] = '{13'h0001, 13'h1000, 13'h1000, 13'h1f75, 13'h0f77};
  ssie_link_if link ();
  ssie_link_if link2 ();
  ssie_encoder #(.FUNC_CYC(100), .POWERUP_CYC(200)) ssie_encoder_i (.mclk(mclk),
    .nrst(nrst), .link(link), .shaft_pos(shaft), .ready(ready));
  // Second encoder on a bench-driven fast link, 320 ns period
  ssie_encoder #(.FUNC_CYC(100), .POWERUP_CYC(200)) ssie_encoder_i2 (.mclk(mclk),
    .nrst(nrst), .link(link2), .shaft_pos(shaft), .ready());
  ssie_ctrl ssie_ctrl_i (.mclk(mclk), .nrst(nrst), .link(link), .start(start),
    .n_bits(n_bits), .dir_in(dir_in), .zero_in(zero_in), .busy(busy), .done(done),
    .rx_word(rx_word));
  ssie_asserts #(.MONO_CYC(ssie_pkg::MONO_CYC)) ssie_asserts_i (.mclk(mclk), .nrst(nrst),
    .clk_p(link.clk_p), .data_p(link.data_p), .dir_sel(link.dir_sel),
    .zero_set(link.zero_set));
  always #20 mclk = ~mclk;
  // ==========
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp_val(input logic [25:0] got, input logic [25:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic burst(input logic [5:0] n);
    int i;
    n_bits <= n;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    for (i = 0; i < 4000 && done !== 1'b1; i++) @(posedge mclk);
    if (i == 4000) begin
      err_total++;
      complete_run();
    end
  endtask
  // Samples on the edge that drives the fall, one cycle after the 3-cycle sync delay
  task automatic pulses2(output logic [12:0] q);
    repeat (13) begin
      link2.clk_p <= 1'b0;
      repeat (4) @(posedge mclk);
      link2.clk_p <= 1'b1;
      repeat (4) @(posedge mclk);
      q = {q[11:0], link2.data_p};
    end
  endtask
  // ==========
  initial begin
    link2.clk_p = 1'b1;
    link2.dir_sel = 1'b0;
    link2.zero_set = 1'b0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    cmp_val({25'h0, ready}, 26'h0);
    repeat (210) @(posedge mclk);
    cmp_val({25'h0, ready}, 26'h1);
    for (int r = 0; r < 5; r++) begin
      dir_in <= row_dir[r];
      shaft <= row_pos[r];
      repeat (120) @(posedge mclk);
      burst(6'h0d);
      cmp_val({13'h0, rx_word[12:0]}, {13'h0, row_exp[r]});
    end
    // Shaft moves mid-burst; both words must match the first capture
    fork
      burst(6'h1a);
      begin
        repeat (300) @(posedge mclk);
        shaft <= 13'h1fff;
      end
    join
    cmp_val(rx_word, {2{13'h0f77}});
    shaft <= 13'h0001;
    @(posedge mclk);
    pulses2(w);
    cmp_val({13'h0, w}, 26'h0001);
    shaft <= 13'h1fff;
    pulses2(w);
    cmp_val({13'h0, w}, 26'h0001);
    repeat (450) @(posedge mclk);
    cmp_val({25'h0, link2.data_p}, 26'h1);
    pulses2(w);
    cmp_val({13'h0, w}, 26'h1000);
    shaft <= 13'h0123;
    zero_in <= 1'b1;
    repeat (120) @(posedge mclk);
    zero_in <= 1'b0;
    repeat (120) @(posedge mclk);
    shaft <= 13'h0128;
    burst(6'h0d);
    cmp_val({13'h0, rx_word[12:0]}, 26'h0007);
    complete_run();
  end
endmodule
`default_nettype wire
